//--- rtl/core_regs.sv
/*
 * Register set of the 8-bit core (flags, accumulator, index, stack pointer,
 * program counter) with a sequencer for source-immediate and source-direct
 * two-byte instructions.
 * Assumes program memory, data RAM and register space each return data one
 * clock after their read strobe, and that the supervisor indication comes from
 * logic on core_clk.
 */
// Function
// - Five core registers, reachable only by instructions; of them only the flags answer a register-space read, at f7.
// - Program counter is sixteen bits and addresses all program memory directly.
// - Program counter is visible as high byte 15..8 and low byte 7..0.
// - Accumulator receives results of logic and arithmetic in source addressing modes.
// - Index register supplies the offset used by indexed addressing.
// - Stack pointer holds top of stack, changed by stack and add instructions.
// - Flags: interrupt enable bit 0, zero bit 1, carry bit 2, supervisor bit 3.
// - Flag bit 4 selects register bank; bits 7..5 reserved.
// - Supervisor bit shows supervisor code running; user code cannot change it.
// - Carry bit set when the last operation carried, else cleared.
// - Zero bit set when the last result is zero, else cleared.
// - Interrupt enable one allows all interrupts, zero blocks all.
// - Arithmetic and logic instructions update flags in their own pattern.
// - Flags readable only at register address f7, changed by AND, OR and XOR forms.
// - Source immediate: second byte is operand, opcode picks A, F, SP or X.
// - Source direct: second byte addresses RAM or registers; A or X destination.
`timescale 1ns/1ps

module core_regs
  import core_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  output logic [PC_W-1:0] prog_addr,
  output logic prog_rd,
  input wire logic [DATA_W-1:0] prog_data,
  output logic [DATA_W-1:0] ram_addr,
  output logic ram_rd,
  input wire logic [DATA_W-1:0] ram_rdata,
  output logic [DATA_W-1:0] reg_addr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic supervisor_active,
  input wire logic irq_request,
  output logic irq_allowed,
  output logic global_interrupt_enable,
  output logic register_bank_select,
  output logic [DATA_W-1:0] core_flags,
  output logic [DATA_W-1:0] core_accumulator,
  output logic [DATA_W-1:0] core_index,
  output logic [DATA_W-1:0] core_stack_pointer,
  output logic [PC_W-1:0] core_program_counter,
  output logic [DATA_W-1:0] core_pc_high,
  output logic [DATA_W-1:0] core_pc_low,
  output logic instr_done,
  output logic illegal_opcode
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic alu_op_t op_of(input logic [7:0] opc);
    op_of = alu_op_t'(opc[OPC_OP_HI:OPC_OP_LO]);
  endfunction : op_of

  function automatic mode_t mode_of(input logic [7:0] opc);
    mode_of = mode_t'(opc[OPC_MODE_HI:OPC_MODE_LO]);
  endfunction : mode_of

  function automatic dest_t dest_of(input logic [7:0] opc);
    dest_of = dest_t'(opc[OPC_DST_HI:OPC_DST_LO]);
  endfunction : dest_of

  // Undefined encodings run as one-byte no-operations so fetch never stalls
  function automatic logic opcode_legal(input logic [7:0] opc);
    alu_op_t op;
    mode_t md;
    dest_t dt;
    logic ok;
    op = op_of(opc);
    md = mode_of(opc);
    dt = dest_of(opc);
    ok = 1'b0;
    if (!opc[OPC_CLASS] && md != MODE_NONE) begin
      unique case (dt)
        DST_ACC, DST_INDEX: ok = 1'b1;
        DST_FLAGS: ok = (md == MODE_IMM) && (op == OP_AND || op == OP_OR || op == OP_XOR);
        DST_SP: ok = (md == MODE_IMM) && (op == OP_MOV || op == OP_ADD);
      endcase
    end
    opcode_legal = ok;
  endfunction : opcode_legal

  // Nine-bit result; bit 8 is carry out, or borrow for the subtract forms
  function automatic logic [8:0] alu(input alu_op_t op, input logic [7:0] a,
                                     input logic [7:0] b, input logic cin);
    logic [8:0] r;
    r = {1'b0, b};
    unique case (op)
      OP_MOV: r = {1'b0, b};
      OP_ADD: r = {1'b0, a} + {1'b0, b};
      OP_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      OP_SUB: r = {1'b0, a} - {1'b0, b};
      OP_SBB: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      OP_AND: r = {1'b0, a & b};
      OP_OR: r = {1'b0, a | b};
      OP_XOR: r = {1'b0, a ^ b};
    endcase
    alu = r;
  endfunction : alu

  // ****************************************
  // State
  // ****************************************
  state_t state_q;
  logic [PC_W-1:0] pc_q;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] index_q;
  logic [DATA_W-1:0] sp_q;
  logic [DATA_W-1:0] flags_q;
  logic super_q;
  logic [DATA_W-1:0] opcode_q;
  logic [DATA_W-1:0] operand_q;
  logic [DATA_W-1:0] src_q;
  logic done_q;
  logic illegal_q;

  // ****************************************
  // State decode
  // ****************************************
  // One named wire per state keeps strobes and captures free of repeated compares
  logic in_fetch;
  logic in_opcode;
  logic in_opnd_req;
  logic in_opnd;
  logic in_data_req;
  logic in_data;
  logic pc_advance;

  assign in_fetch = (state_q == ST_FETCH);
  assign in_opcode = (state_q == ST_OPCODE);
  assign in_opnd_req = (state_q == ST_OPND_REQ);
  assign in_opnd = (state_q == ST_OPND);
  assign in_data_req = (state_q == ST_DATA_REQ);
  assign in_data = (state_q == ST_DATA);
  // Counter moves once per fetched byte, so a two-byte instruction steps it twice
  assign pc_advance = in_opcode || in_opnd;

  // ****************************************
  // Decode and datapath
  // ****************************************
  alu_op_t cur_op;
  mode_t cur_mode;
  dest_t cur_dest;
  logic fetched_legal;
  logic in_exec;
  logic flags_hit;
  logic is_arith;
  logic is_logic;
  logic [DATA_W-1:0] flags_view;
  logic [DATA_W-1:0] dst_val;
  logic [8:0] result;
  logic [DATA_W-1:0] result_byte;
  logic carry_out;
  logic result_zero;
  logic wr_acc;
  logic wr_index;
  logic wr_flags;
  logic wr_sp;
  logic upd_zero;
  logic upd_carry;
  logic [DATA_W-1:0] flags_d;
  logic [DATA_W-1:0] acc_d;
  logic [DATA_W-1:0] index_d;
  logic [DATA_W-1:0] sp_d;
  logic [PC_W-1:0] pc_d;
  state_t state_d;

  assign cur_op = op_of(opcode_q);
  assign cur_mode = mode_of(opcode_q);
  assign cur_dest = dest_of(opcode_q);
  assign fetched_legal = opcode_legal(prog_data);
  assign in_exec = (state_q == ST_EXEC);
  // Register-space reads of this address see the flags, not the outside space
  assign flags_hit = (operand_q == FLAGS_REG_ADDR);

  // Supervisor bit is hardware owned; reserved bits read as zero
  assign flags_view = (flags_q & FLAGS_SW_MASK) | (DATA_W'(super_q) << FLAG_SUPER);

  assign dst_val = (cur_dest == DST_ACC) ? acc_q :
                   (cur_dest == DST_INDEX) ? index_q :
                   (cur_dest == DST_FLAGS) ? flags_view : sp_q;
  assign result = alu(cur_op, dst_val, src_q, flags_q[FLAG_CARRY]);
  // Split once here so every writer takes the same byte and the same carry
  assign result_byte = result[DATA_W-1:0];
  assign carry_out = result[DATA_W];
  assign result_zero = (result_byte == BYTE_ZERO);
  assign is_arith = (cur_op == OP_ADD) || (cur_op == OP_ADC) ||
                    (cur_op == OP_SUB) || (cur_op == OP_SBB);
  assign is_logic = (cur_op == OP_AND) || (cur_op == OP_OR) || (cur_op == OP_XOR);

  assign wr_acc = in_exec && (cur_dest == DST_ACC);
  assign wr_index = in_exec && (cur_dest == DST_INDEX);
  assign wr_flags = in_exec && (cur_dest == DST_FLAGS);
  assign wr_sp = in_exec && (cur_dest == DST_SP);

  // Moves into the index leave flags alone; moves into A still report zero
  assign upd_zero = (wr_acc || wr_index) && (is_arith || is_logic || wr_acc);
  // Logic operations have no carry out, so carry keeps its last value
  assign upd_carry = (wr_acc || wr_index) && is_arith;

  assign acc_d = wr_acc ? result_byte : acc_q;
  assign index_d = wr_index ? result_byte : index_q;
  assign sp_d = wr_sp ? result_byte : sp_q;

  // A write to F and a flag update never meet: one instruction has one destination
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      // Only the writable bits change; supervisor bit cannot be forced by code
      flags_d = result_byte & FLAGS_SW_MASK;
    end else begin
      if (upd_zero) begin
        flags_d[FLAG_ZERO] = result_zero;
      end
      if (upd_carry) begin
        flags_d[FLAG_CARRY] = carry_out;
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign pc_d = pc_advance ? pc_q + PC_STEP : pc_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_FETCH: state_d = ST_OPCODE;
      // An undefined opcode costs one byte; the counter has already stepped past it
      ST_OPCODE: state_d = fetched_legal ? ST_OPND_REQ : ST_FETCH;
      ST_OPND_REQ: state_d = ST_OPND;
      ST_OPND: state_d = (cur_mode == MODE_IMM) ? ST_EXEC : ST_DATA_REQ;
      ST_DATA_REQ: state_d = ST_DATA;
      ST_DATA: state_d = ST_EXEC;
      ST_EXEC: state_d = ST_FETCH;
      default: state_d = ST_FETCH;
    endcase
  end

  // ****************************************
  // Memory strobes
  // ****************************************
  // Program fetches come straight from the counter, full sixteen bits wide
  assign prog_addr = pc_q;
  // Strobes last one cycle; memories must answer at the next edge, with no wait states
  assign prog_rd = in_fetch || in_opnd_req;
  assign ram_addr = operand_q;
  assign reg_addr = operand_q;
  assign ram_rd = in_data_req && (cur_mode == MODE_RAM);
  // Core registers never appear on the register space; the flags answer locally
  assign reg_rd = in_data_req && (cur_mode == MODE_REG) && !flags_hit;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_FETCH;
      pc_q <= PC_RESET;
      acc_q <= ACC_RESET;
      index_q <= INDEX_RESET;
      sp_q <= SP_RESET;
      flags_q <= FLAGS_RESET;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      index_q <= index_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
    end
  end

  // Supervisor state tracks the code being run, one cycle behind its source
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      super_q <= 1'b0;
    end else begin
      super_q <= supervisor_active;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opcode_q <= BYTE_ZERO;
      operand_q <= BYTE_ZERO;
      src_q <= BYTE_ZERO;
    end else begin
      if (in_opcode) begin
        opcode_q <= prog_data;
      end
      if (in_opnd) begin
        operand_q <= prog_data;
        src_q <= prog_data;
      end
      // The flags address is served from the local view; the outside space never sees it
      if (in_data) begin
        src_q <= (cur_mode == MODE_RAM) ? ram_rdata :
                 (flags_hit ? flags_view : reg_rdata);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= in_exec;
      illegal_q <= in_opcode && !fetched_legal;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign global_interrupt_enable = flags_q[FLAG_GIE];
  // Gate every interrupt source in one place so no path bypasses the enable
  assign irq_allowed = irq_request && flags_q[FLAG_GIE];
  assign register_bank_select = flags_q[FLAG_BANK];
  assign core_flags = flags_view;
  assign core_accumulator = acc_q;
  assign core_index = index_q;
  assign core_stack_pointer = sp_q;
  assign core_program_counter = pc_q;
  // Both byte views are wires on the one counter, so they can never disagree
  assign core_pc_high = pc_q[PC_W-1:DATA_W];
  assign core_pc_low = pc_q[DATA_W-1:0];
  assign instr_done = done_q;
  assign illegal_opcode = illegal_q;

endmodule : core_regs

//--- common/core_regs_pkg.sv
/*
 * Constants, field layouts, reset values and opcode encodings shared by the
 * register set and operand sequencer of the 8-bit core.
 * Assumes a single core clock and memories that answer one cycle after a read strobe.
 */
package core_regs_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int PC_W = 16;

  // ****************************************
  // Flag bit positions and values
  // ****************************************
  localparam int FLAG_GIE = 0;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_CARRY = 2;
  localparam int FLAG_SUPER = 3;
  localparam int FLAG_BANK = 4;
  // Bits that logical flag instructions may change; super and reserved stay out
  localparam logic [7:0] FLAGS_SW_MASK = 8'h17;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] FLAGS_REG_ADDR = 8'hf7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************
  // Opcode layout: [7] class, [6:4] operation, [3:2] mode, [1:0] destination
  // ****************************************
  localparam int OPC_CLASS = 7;
  localparam int OPC_OP_HI = 6;
  localparam int OPC_OP_LO = 4;
  localparam int OPC_MODE_HI = 3;
  localparam int OPC_MODE_LO = 2;
  localparam int OPC_DST_HI = 1;
  localparam int OPC_DST_LO = 0;

  typedef enum logic [2:0] {
    OP_MOV = 3'h0, OP_ADD = 3'h1, OP_ADC = 3'h2, OP_SUB = 3'h3,
    OP_SBB = 3'h4, OP_AND = 3'h5, OP_OR = 3'h6, OP_XOR = 3'h7
  } alu_op_t;

  typedef enum logic [1:0] {
    MODE_IMM = 2'h0, MODE_RAM = 2'h1, MODE_REG = 2'h2, MODE_NONE = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    DST_ACC = 2'h0, DST_INDEX = 2'h1, DST_FLAGS = 2'h2, DST_SP = 2'h3
  } dest_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'h0, ST_OPCODE = 3'h1, ST_OPND_REQ = 3'h2, ST_OPND = 3'h3,
    ST_DATA_REQ = 3'h4, ST_DATA = 3'h5, ST_EXEC = 3'h6
  } state_t;

endpackage : core_regs_pkg

//--- verification/core_regs_properties.sv
/* Concurrent checks on the ports of the core register set.
   Assumes it is bound onto core_regs and that all ports share core_clk. */
`timescale 1ns/1ps
module core_regs_properties
  import core_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic prog_rd,
  input wire logic ram_rd,
  input wire logic [DATA_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic supervisor_active,
  input wire logic irq_request,
  input wire logic irq_allowed,
  input wire logic global_interrupt_enable,
  input wire logic register_bank_select,
  input wire logic [DATA_W-1:0] core_flags,
  input wire logic [DATA_W-1:0] core_accumulator,
  input wire logic [DATA_W-1:0] core_index,
  input wire logic [DATA_W-1:0] core_stack_pointer,
  input wire logic [PC_W-1:0] core_program_counter,
  input wire logic [DATA_W-1:0] core_pc_high,
  input wire logic [DATA_W-1:0] core_pc_low,
  input wire logic instr_done,
  input wire logic illegal_opcode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****
  // Properties
  // ****
  property p_pc_bytes;
    {core_pc_high, core_pc_low} == core_program_counter && prog_addr == core_program_counter;
  endproperty
  a_pc_bytes: assert property (p_pc_bytes) else $error("pc byte view wrong");
  property p_flag_view;
    global_interrupt_enable == core_flags[FLAG_GIE] && core_flags[7:5] == 3'h0 &&
      register_bank_select == core_flags[FLAG_BANK];
  endproperty
  a_flag_view: assert property (p_flag_view) else $error("flag layout wrong");
  // Super lags its input by one edge, so the first edge after reset is skipped
  property p_super;
    !$past(rst) |-> core_flags[FLAG_SUPER] == $past(supervisor_active);
  endproperty
  a_super: assert property (p_super) else $error("super bit wrong");
  property p_irq;
    irq_allowed == (irq_request && core_flags[FLAG_GIE]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq gating wrong");
  property p_pc_step;
    $changed(core_program_counter) |-> core_program_counter == $past(core_program_counter) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  property p_fetch_gap;
    prog_rd |=> !prog_rd;
  endproperty
  a_fetch_gap: assert property (p_fetch_gap) else $error("fetch strobe too long");
  property p_flags_internal;
    reg_rd |-> reg_addr != FLAGS_REG_ADDR;
  endproperty
  a_flags_internal: assert property (p_flags_internal) else $error("flags read outside");
  property p_direct_len;
    (ram_rd || reg_rd) |-> !(ram_rd && reg_rd) ##1 !(ram_rd || reg_rd) ##2 instr_done;
  endproperty
  a_direct_len: assert property (p_direct_len) else $error("direct sequence wrong");
  property p_regs_quiet;
    $changed({core_accumulator, core_index, core_stack_pointer}) |-> instr_done;
  endproperty
  a_regs_quiet: assert property (p_regs_quiet) else $error("register changed idle");
  property p_flags_quiet;
    $changed(core_flags & FLAGS_SW_MASK) |-> instr_done;
  endproperty
  a_flags_quiet: assert property (p_flags_quiet) else $error("flags changed idle");
  property p_done_pulse;
    instr_done |=> !instr_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  c_ram: cover property (ram_rd);
  c_reg: cover property (reg_rd);
  c_illegal: cover property (illegal_opcode);
endmodule : core_regs_properties

bind core_regs core_regs_properties i_core_regs_properties (.*);

//--- verification/mem_model.sv
/* Far side model: program memory, data RAM and register space.
   Assumes one cycle read latency on core_clk and preloading by the bench. */
`timescale 1ns/1ps
module mem_model
  import core_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic prog_rd,
  output logic [DATA_W-1:0] prog_data,
  input wire logic [DATA_W-1:0] ram_addr,
  input wire logic ram_rd,
  output logic [DATA_W-1:0] ram_rdata,
  input wire logic [DATA_W-1:0] reg_addr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata
);
  // ****
  // Storage
  // ****
  // Only 256 program bytes are held; the test code stays short
  logic [DATA_W-1:0] prog_mem [256];
  logic [DATA_W-1:0] ram_mem [256];
  logic [DATA_W-1:0] reg_mem [256];
  initial begin
    prog_data = 8'h00;
    ram_rdata = 8'h00;
    reg_rdata = 8'h00;
  end
  // ****
  // Read ports
  // ****
  // Idle buses toggle so a late sample never sees stale data
  always @(posedge core_clk) begin
    prog_data <= prog_rd ? prog_mem[prog_addr[7:0]] : ~prog_data;
    ram_rdata <= ram_rd ? ram_mem[ram_addr] : ~ram_rdata;
    reg_rdata <= reg_rd ? reg_mem[reg_addr] : ~reg_rdata;
  end
endmodule : mem_model

//--- verification/testbench.sv
/* Self-checking bench for the core register set.
   Assumes mem_model as far side and the checker bound onto the core. */
`timescale 1ns/1ps
module testbench
  import core_regs_pkg::*;
;
  typedef struct packed {
    logic [7:0] opc, opnd, data, a, x, sp, f;
  } row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic supervisor_active = 1'b0;
  logic irq_request = 1'b1;
  logic [PC_W-1:0] prog_addr, core_program_counter;
  logic [DATA_W-1:0] prog_data, ram_addr, ram_rdata, reg_addr, reg_rdata;
  logic [DATA_W-1:0] core_flags, core_accumulator, core_index, core_stack_pointer;
  logic [DATA_W-1:0] core_pc_high, core_pc_low;
  logic prog_rd, ram_rd, reg_rd, irq_allowed, global_interrupt_enable;
  logic register_bank_select, instr_done, illegal_opcode;
  int n_fail = 0;
  int n_checks = 0;
  // Fields: opcode, operand, source data, then expected A, X, SP, F
  row_t rows [16] = '{56'h007f007f000000, 56'h10810000000006, 56'h20010002000000,
    56'h300300ff000004, 56'h40fe0000000002, 56'h01550000550002, 56'h64200f0f550000,
    56'h5930f00f500000, 56'h6211000f500011, 56'h78f7aa1e500011, 56'h62ff001e500017,
    56'h52fd001e500015, 56'h0380001e508015, 56'h1390001e501015, 56'h0521001e001015,
    56'h1422e200001017};
  core_regs i_core_regs (.*);
  mem_model i_mem_model (.*);
  always #2.5 core_clk = ~core_clk;
  // ****
  // Tasks
  // ****
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16
  task automatic check_reset();
    chk16("pc", PC_RESET, core_program_counter);
    chk8("acc", ACC_RESET, core_accumulator);
    chk8("index", INDEX_RESET, core_index);
    chk8("sp", SP_RESET, core_stack_pointer);
    chk8("flags", FLAGS_RESET, core_flags);
    chk8("fetch", 8'h01, {7'h00, prog_rd});
  endtask : check_reset
  task automatic wait_done();
    for (int k = 0; k < 20; k++) begin
      @(negedge core_clk);
      if (instr_done === 1'b1) return;
    end
    chk8("done", 8'h01, 8'h00);
  endtask : wait_done
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // ****
  // Sequence
  // ****
  initial begin
    logic seen;
    for (int k = 0; k < 256; k++) i_mem_model.prog_mem[k] = 8'h0c;
    foreach (rows[i]) begin
      i_mem_model.prog_mem[2 * i] = rows[i].opc;
      i_mem_model.prog_mem[2 * i + 1] = rows[i].opnd;
      i_mem_model.ram_mem[rows[i].opnd] = rows[i].data;
      i_mem_model.reg_mem[rows[i].opnd] = rows[i].data;
    end
    repeat (4) @(negedge core_clk);
    check_reset();
    rst = 1'b0;
    foreach (rows[i]) begin
      wait_done();
      chk8("acc", rows[i].a, core_accumulator);
      chk8("index", rows[i].x, core_index);
      chk8("sp", rows[i].sp, core_stack_pointer);
      chk8("flags", rows[i].f, core_flags);
      chk16("pc", 16'(2 * i + 2), core_program_counter);
    end
    seen = 1'b0;
    for (int k = 0; k < 10 && !seen; k++) begin
      @(negedge core_clk);
      seen = (illegal_opcode === 1'b1);
    end
    chk8("illegal", 8'h01, {7'h00, seen});
    supervisor_active = 1'b1;
    repeat (2) @(negedge core_clk);
    chk8("flags", 8'h1f, core_flags);
    chk8("bank", 8'h01, {7'h00, register_bank_select});
    chk8("irq", 8'h01, {7'h00, irq_allowed});
    irq_request = 1'b0;
    supervisor_active = 1'b0;
    @(negedge core_clk);
    chk8("irq", 8'h00, {7'h00, irq_allowed});
    rst = 1'b1;
    @(negedge core_clk);
    check_reset();
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    finish_test();
  end
  // Tests need under 300 cycles; this allows several times that
  initial begin
    #5000;
    n_fail++;
    finish_test();
  end
endmodule : testbench
